// ===== hw/boxcar_pkg.sv
package boxcar_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GATE_OFS = 8'h04;
  localparam logic [7:0] AVG_OFS = 8'h08;
  localparam logic [7:0] ZOOM_OFS = 8'h0c;
  localparam logic [7:0] HARM_OFS = 8'h10;
  localparam logic [7:0] SHOT_LO_OFS = 8'h14;
  localparam logic [7:0] SHOT_HI_OFS = 8'h18;
  localparam logic [7:0] STEP_OFS = 8'h1c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] STATE_OFS = 8'h28;
  localparam logic [7:0] FILT_OFS = 8'h2c;

  // Control register fields.
  localparam int BOX_EN_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int SINGLE_BIT = 2;
  localparam int RANGE_RST_BIT = 3;
  localparam int BIND_BIT = 4;
  localparam int BOX_IN_BIT = 5;
  localparam int BOX_OSC_LSB = 8;
  localparam int PWA_SRC_LSB = 16;
  localparam int PWA_OSC_LSB = 20;

  // Interrupt status bits.
  localparam int EV_SHOT = 0;
  localparam int EV_OVF = 1;
  localparam int EV_UNEVEN = 2;
  localparam int EV_PERIOD = 3;
  localparam int NUM_EV = 4;

  // Reset values and fixed figures.
  localparam logic [31:0] GATE_RST = 32'h4000_0000;
  localparam logic [15:0] AVG_RST = 16'h0001;
  localparam logic [9:0] HARM_RST = 10'h001;
  localparam logic [47:0] SHOT_RST = 48'h0000_0000_0400;
  localparam logic [31:0] STEP_RST = 32'h8000_0000;
  localparam logic [3:0] ZOOM_FULL = 4'h0;
  localparam int FILT_DEPTH = 512;
  localparam int NUM_BINS = 1024;
  localparam int BIN_SUM_W = 32;
  localparam int BIN_CNT_W = 16;
  localparam int SAMPLE_RATE_MSA = 1800;
  localparam int PWA_RATE_MSA = 450;

  // Analyzer input sources.
  typedef enum logic [2:0] {
    SRC_SIG0 = 3'h0, SRC_SIG1 = 3'h1, SRC_TRIG0 = 3'h2, SRC_TRIG1 = 3'h3,
    SRC_AUX_IN = 3'h4, SRC_AUX_OUT = 3'h5, SRC_DEMOD4 = 3'h6, SRC_DEMOD8 = 3'h7
  } pwa_src_t;

  typedef struct packed {
    logic [9:0] bin;
    logic [BIN_SUM_W-1:0] sum;
    logic [BIN_CNT_W-1:0] cnt;
  } bin_word_t;

  typedef struct packed {
    logic valid;
    logic signed [31:0] sum;
  } period_sum_t;

endpackage

// ===== hw/moving_average.sv
`timescale 1ns/1ps
module moving_average #(
  parameter int DEPTH = 512,
  parameter int IW = 32,
  parameter int OW = 48
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Per-period sums.
  input wire logic restart,
  input wire logic in_valid,
  input wire logic signed [IW-1:0] in_sum,
  input wire logic [15:0] periods,
  // Window total.
  output logic out_valid,
  output logic signed [OW-1:0] out_sum
);
  localparam int AW = $clog2(DEPTH);
  logic signed [OW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW:0] fill_q;
  logic [15:0] grp_q;
  logic signed [OW-1:0] part_q;
  logic [AW:0] entries;
  logic [15:0] group;
  logic signed [OW-1:0] part_d;
  logic [AW-1:0] old_idx;

  // Long windows fold several periods into each stored entry.
  always_comb begin
    if (periods > 16'(DEPTH)) begin
      entries = (AW+1)'(DEPTH);
      group = 16'(({1'b0, periods} + 17'(DEPTH - 1)) >> AW);
    end else begin
      entries = (periods == 16'h0000) ? (AW+1)'(1) : periods[AW:0];
      group = 16'h0001;
    end
    part_d = part_q + OW'(in_sum);
    old_idx = wr_q - entries[AW-1:0];
  end

  always_ff @(posedge clock) begin
    if (in_valid && grp_q + 16'h0001 >= group) begin
      mem[wr_q] <= part_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      fill_q <= '0;
      grp_q <= '0;
      part_q <= '0;
      out_valid <= 1'b0;
      out_sum <= '0;
    end else if (restart) begin
      wr_q <= '0;
      fill_q <= '0;
      grp_q <= '0;
      part_q <= '0;
      out_valid <= 1'b0;
      out_sum <= '0;
    end else begin
      out_valid <= 1'b0;
      if (in_valid) begin
        if (grp_q + 16'h0001 >= group) begin
          grp_q <= '0;
          part_q <= '0;
          wr_q <= wr_q + 1'b1;
          out_valid <= 1'b1;
          if (fill_q >= entries) begin
            out_sum <= out_sum + part_d - mem[old_idx];
          end else begin
            out_sum <= out_sum + part_d;
            fill_q <= fill_q + 1'b1;
          end
        end else begin
          grp_q <= grp_q + 16'h0001;
          part_q <= part_d;
        end
      end
    end
  end
endmodule

// ===== hw/bin_memory.sv
`timescale 1ns/1ps
module bin_memory #(
  parameter int BINS = 1024,
  parameter int SW = 32,
  parameter int CW = 16
) (
  // Clock.
  input wire logic clock,
  // Sample accumulation.
  input wire logic acc_en,
  input wire logic [$clog2(BINS)-1:0] acc_bin,
  input wire logic signed [15:0] acc_data,
  output logic acc_ovf,
  // Readout and clearing.
  input wire logic clr_en,
  input wire logic [$clog2(BINS)-1:0] rd_bin,
  output logic [SW-1:0] rd_sum,
  output logic [CW-1:0] rd_cnt
);
  logic signed [SW-1:0] sums [BINS];
  logic [CW-1:0] cnts [BINS];
  logic signed [SW-1:0] sum_d;
  logic cnt_full;

  always_comb begin
    sum_d = sums[acc_bin] + SW'(acc_data);
    cnt_full = cnts[acc_bin] == {CW{1'b1}};
    // Signed wrap of the sum or a saturated count both flag overflow.
    acc_ovf = acc_en && (cnt_full ||
      (sums[acc_bin][SW-1] == acc_data[15] && sum_d[SW-1] != acc_data[15]));
    rd_sum = sums[rd_bin];
    rd_cnt = cnts[rd_bin];
  end

  always_ff @(posedge clock) begin
    if (clr_en) begin
      sums[rd_bin] <= '0;
      cnts[rd_bin] <= '0;
    end else if (acc_en) begin
      sums[acc_bin] <= sum_d;
      if (!cnt_full) begin
        cnts[acc_bin] <= cnts[acc_bin] + 1'b1;
      end
    end
  end
endmodule

// ===== hw/boxcar_averager.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module boxcar_averager #(
  parameter int NUM_OSC = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample stream and reference phases.
  input wire logic in_valid,
  input wire logic signed [15:0] src_data [8],
  input wire logic [15:0] osc_phase [NUM_OSC],
  // Period sums and filtered output.
  output boxcar_pkg::period_sum_t period_out,
  output logic filt_valid,
  output logic signed [47:0] filt_sum,
  // Bin dump stream.
  output logic dump_valid,
  output boxcar_pkg::bin_word_t dump_word,
  input wire logic dump_ready,
  // Interrupt.
  output logic irq
);
  localparam int OW = $clog2(NUM_OSC);

  typedef enum logic [3:0] {
    ST_CLEAR = 4'b0001, ST_IDLE = 4'b0010, ST_ACQ = 4'b0100, ST_DUMP = 4'b1000
  } pwa_state_t;

  logic rst_m_q, rst_s_n;
  logic [31:0] ctrl_q, gate_q, step_q;
  logic [15:0] avg_q, zoom_start_q;
  logic [3:0] zoom_shift_q;
  logic [9:0] harm_q;
  logic [47:0] shot_q;
  logic single_q;
  logic [boxcar_pkg::NUM_EV-1:0] stat_q, mask_q, events;
  logic wr_acc, setup;
  pwa_state_t st_q;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_n <= rst_m_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file.

  assign wr_acc = psel && penable && pwrite;
  assign setup = psel && !penable;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= boxcar_pkg::FILT_OFS;
  endfunction

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctrl_q <= 32'h0000_0000;
      gate_q <= boxcar_pkg::GATE_RST;
      avg_q <= boxcar_pkg::AVG_RST;
      zoom_start_q <= 16'h0000;
      zoom_shift_q <= boxcar_pkg::ZOOM_FULL;
      harm_q <= boxcar_pkg::HARM_RST;
      shot_q <= boxcar_pkg::SHOT_RST;
      step_q <= boxcar_pkg::STEP_RST;
      mask_q <= '0;
    end else if (wr_acc) begin
      case (paddr)
        boxcar_pkg::CTRL_OFS: begin
          ctrl_q <= pwdata;
          if (pwdata[boxcar_pkg::RANGE_RST_BIT]) begin
            zoom_start_q <= 16'h0000;
            zoom_shift_q <= boxcar_pkg::ZOOM_FULL;
          end
        end
        boxcar_pkg::GATE_OFS: gate_q <= pwdata;
        boxcar_pkg::AVG_OFS: avg_q <= pwdata[15:0];
        boxcar_pkg::ZOOM_OFS: begin
          zoom_start_q <= pwdata[15:0];
          zoom_shift_q <= (pwdata[19:16] > 4'h6) ? 4'h6 : pwdata[19:16];
        end
        boxcar_pkg::HARM_OFS: harm_q <= (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
        boxcar_pkg::SHOT_LO_OFS: shot_q[31:0] <= pwdata;
        boxcar_pkg::SHOT_HI_OFS: shot_q[47:32] <= {1'b0, pwdata[14:0]};
        boxcar_pkg::STEP_OFS: step_q <= pwdata;
        boxcar_pkg::IRQ_MASK_OFS: mask_q <= pwdata[boxcar_pkg::NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_acc && paddr == boxcar_pkg::IRQ_STAT_OFS) begin
        stat_q <= (stat_q & ~pwdata[boxcar_pkg::NUM_EV-1:0]) | events;
      end else begin
        stat_q <= stat_q | events;
      end
      irq <= |(stat_q & mask_q);
    end
  end

  logic even_q, ovf_now_q;

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= !mapped(paddr);
        case (paddr)
          boxcar_pkg::CTRL_OFS: prdata <= ctrl_q & 32'hfffffff3;
          boxcar_pkg::GATE_OFS: prdata <= gate_q;
          boxcar_pkg::AVG_OFS: prdata <= {16'h0000, avg_q};
          boxcar_pkg::ZOOM_OFS: prdata <= {12'h000, zoom_shift_q, zoom_start_q};
          boxcar_pkg::HARM_OFS: prdata <= {22'h000000, harm_q};
          boxcar_pkg::SHOT_LO_OFS: prdata <= shot_q[31:0];
          boxcar_pkg::SHOT_HI_OFS: prdata <= {16'h0000, shot_q[47:32]};
          boxcar_pkg::STEP_OFS: prdata <= step_q;
          boxcar_pkg::IRQ_STAT_OFS: prdata <= {28'h0000000, stat_q};
          boxcar_pkg::IRQ_MASK_OFS: prdata <= {28'h0000000, mask_q};
          boxcar_pkg::STATE_OFS: prdata <= {25'h0000000, ovf_now_q, even_q, single_q, st_q};
          boxcar_pkg::FILT_OFS: prdata <= filt_sum[31:0];
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boxcar gate and period adder.

  logic [OW-1:0] box_osc;
  logic [15:0] box_phase, last_phase_q;
  logic signed [15:0] box_sample;
  logic gated, wrap;
  logic signed [31:0] acc_q, gated_val;

  always_comb begin
    box_osc = ctrl_q[boxcar_pkg::BOX_OSC_LSB +: OW];
    box_phase = osc_phase[box_osc];
    box_sample = src_data[{2'b00, ctrl_q[boxcar_pkg::BOX_IN_BIT]}];
    gated = (box_phase - gate_q[15:0]) < gate_q[31:16];
    gated_val = gated ? 32'(box_sample) : 32'sh0;
    wrap = in_valid && box_phase < last_phase_q;
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      acc_q <= '0;
      last_phase_q <= 16'h0000;
      period_out <= '0;
    end else if (!ctrl_q[boxcar_pkg::BOX_EN_BIT]) begin
      acc_q <= '0;
      period_out <= '0;
    end else begin
      period_out.valid <= wrap;
      if (in_valid) begin
        last_phase_q <= box_phase;
        if (wrap) begin
          period_out.sum <= acc_q;
          acc_q <= gated_val;
        end else begin
          acc_q <= acc_q + gated_val;
        end
      end
    end
  end

  moving_average #(
    .DEPTH(boxcar_pkg::FILT_DEPTH), .IW(32), .OW(48)
  ) u_filter (
    .clock(clock),
    .rst_n(rst_s_n),
    .restart(!ctrl_q[boxcar_pkg::BOX_EN_BIT]),
    .in_valid(period_out.valid),
    .in_sum(period_out.sum),
    .periods(avg_q),
    .out_valid(filt_valid),
    .out_sum(filt_sum)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Analyzer source, phase and resampling.

  logic bind_on;
  logic [2:0] pwa_src;
  logic [OW-1:0] pwa_osc;
  logic [25:0] harm_prod;
  logic [15:0] pwa_phase, rel;
  logic [32:0] step_sum;
  logic [31:0] rs_acc_q;
  logic rs_tick;
  logic signed [15:0] pwa_in;
  logic [9:0] bin_idx;
  logic in_zoom;

  always_comb begin
    bind_on = ctrl_q[boxcar_pkg::BIND_BIT];
    pwa_src = bind_on ? {2'b00, ctrl_q[boxcar_pkg::BOX_IN_BIT]}
                      : ctrl_q[boxcar_pkg::PWA_SRC_LSB +: 3];
    pwa_osc = bind_on ? box_osc : ctrl_q[boxcar_pkg::PWA_OSC_LSB +: OW];
    harm_prod = osc_phase[pwa_osc] * harm_q;
    pwa_phase = harm_prod[15:0];
    pwa_in = src_data[pwa_src];
    step_sum = {1'b0, rs_acc_q} + {1'b0, step_q};
    rs_tick = step_sum[32];
    rel = pwa_phase - zoom_start_q;
    in_zoom = (rel >> (5'd16 - 5'(zoom_shift_q))) == 16'h0000;
    bin_idx = 10'(rel >> (4'd6 - zoom_shift_q));
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rs_acc_q <= '0;
    end else begin
      rs_acc_q <= step_sum[31:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bin acquisition, dump and clear.

  logic [9:0] idx_q;
  logic [47:0] taken_q;
  logic [15:0] cmin_q, cmax_q;
  logic [31:0] rd_sum;
  logic [15:0] rd_cnt;
  logic acc_en, acc_ovf, clr_en, load, last_bin, start_req;

  always_comb begin
    acc_en = st_q == ST_ACQ && rs_tick && in_zoom;
    load = st_q == ST_DUMP && (!dump_valid || dump_ready);
    last_bin = idx_q == 10'h3ff;
    clr_en = st_q == ST_CLEAR || (load && !(dump_valid && last_bin && idx_q == 10'h000));
    start_req = ctrl_q[boxcar_pkg::RUN_BIT] || single_q;
  end

  bin_memory #(
    .BINS(boxcar_pkg::NUM_BINS), .SW(boxcar_pkg::BIN_SUM_W), .CW(boxcar_pkg::BIN_CNT_W)
  ) u_bins (
    .clock(clock),
    .acc_en(acc_en),
    .acc_bin(bin_idx),
    .acc_data(pwa_in),
    .acc_ovf(acc_ovf),
    .clr_en(clr_en),
    .rd_bin(idx_q),
    .rd_sum(rd_sum),
    .rd_cnt(rd_cnt)
  );

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      single_q <= 1'b0;
    end else if (wr_acc && paddr == boxcar_pkg::CTRL_OFS && pwdata[boxcar_pkg::SINGLE_BIT]) begin
      single_q <= 1'b1;
    end else if (st_q == ST_DUMP && load && last_bin && dump_valid) begin
      single_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_q <= ST_CLEAR;
      idx_q <= 10'h000;
      taken_q <= '0;
      dump_valid <= 1'b0;
      dump_word <= '0;
      cmin_q <= 16'hffff;
      cmax_q <= 16'h0000;
      even_q <= 1'b0;
    end else begin
      case (st_q)
        ST_CLEAR: begin
          idx_q <= idx_q + 10'h001;
          if (last_bin) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          taken_q <= '0;
          if (start_req) begin
            st_q <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (!start_req) begin
            st_q <= ST_IDLE;
          end else if (rs_tick) begin
            taken_q <= taken_q + 48'h1;
            if (taken_q + 48'h1 >= shot_q) begin
              st_q <= ST_DUMP;
              idx_q <= 10'h000;
              cmin_q <= 16'hffff;
              cmax_q <= 16'h0000;
            end
          end
        end
        ST_DUMP: begin
          if (load) begin
            if (dump_valid && last_bin && dump_word.bin == 10'h3ff) begin
              dump_valid <= 1'b0;
              even_q <= (cmax_q - cmin_q) <= 16'h0001;
              taken_q <= '0;
              idx_q <= 10'h000;
              st_q <= ctrl_q[boxcar_pkg::RUN_BIT] ? ST_ACQ : ST_IDLE;
            end else begin
              dump_valid <= 1'b1;
              dump_word <= '{bin: idx_q, sum: rd_sum, cnt: rd_cnt};
              if (rd_cnt < cmin_q) cmin_q <= rd_cnt;
              if (rd_cnt > cmax_q) cmax_q <= rd_cnt;
              if (!last_bin) idx_q <= idx_q + 10'h001;
            end
          end
        end
        default: st_q <= ST_CLEAR;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events.

  logic shot_done, uneven;

  always_comb begin
    shot_done = st_q == ST_DUMP && load && dump_valid && last_bin && dump_word.bin == 10'h3ff;
    uneven = shot_done && (cmax_q - cmin_q) > 16'h0001;
    events = '0;
    events[boxcar_pkg::EV_SHOT] = shot_done;
    events[boxcar_pkg::EV_OVF] = acc_ovf;
    events[boxcar_pkg::EV_UNEVEN] = uneven;
    events[boxcar_pkg::EV_PERIOD] = filt_valid;
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ovf_now_q <= 1'b0;
    end else if (shot_done) begin
      ovf_now_q <= 1'b0;
    end else if (acc_ovf) begin
      ovf_now_q <= 1'b1;
    end
  end
endmodule

// ===== verif/boxcar_asserts.sv
`timescale 1ns/1ps
module boxcar_asserts (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register bus.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Stream side.
  input wire logic in_valid,
  input wire boxcar_pkg::period_sum_t period_out,
  input wire logic filt_valid,
  input wire logic dump_valid,
  input wire boxcar_pkg::bin_word_t dump_word,
  input wire logic dump_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    dump_valid && dump_ready;
  endsequence
  sequence s_wait;
    dump_valid && !dump_ready;
  endsequence
  a_ready_soon: assert property ($rose(rst_n) |-> ##[1:4] pready)
    else $error("pready late after reset");
  a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h2c |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (psel && penable && pready && paddr <= 8'h2c &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  a_word_hold: assert property (s_wait |=> dump_valid && $stable(dump_word))
    else $error("dump word dropped");
  a_bin_step: assert property (s_take ##0 (dump_word.bin != 10'h3ff) |=>
    dump_valid && dump_word.bin == $past(dump_word.bin) + 10'h1) else $error("bin order");
  a_dump_end: assert property (s_take ##0 (dump_word.bin == 10'h3ff) |=> !dump_valid)
    else $error("dump runs past last bin");
  a_period_one: assert property (period_out.valid |=> !period_out.valid)
    else $error("period pulse too long");
  a_period_cause: assert property (period_out.valid |-> $past(in_valid))
    else $error("period pulse without sample");
  a_filt_after: assert property (filt_valid |-> $past(period_out.valid))
    else $error("filter update without period");
endmodule

// ===== verif/phase_source.sv
`timescale 1ns/1ps
module phase_source (
  // Clock and control.
  input wire logic clock,
  input wire logic run,
  input wire logic stall,
  // Samples and phases.
  output logic in_valid,
  output logic signed [15:0] src_data [8],
  output logic [15:0] osc_phase [4],
  // Host readout.
  output logic dump_ready
);
  logic toggle_q;
  initial begin
    toggle_q = 1'b0;
    in_valid = 1'b0;
    for (int k = 0; k < 8; k++) begin
      src_data[k] = 16'(k + 3);
    end
    for (int k = 0; k < 4; k++) begin
      osc_phase[k] = 16'h0000;
    end
  end
  // Every oscillator wraps once in 16 cycles.
  always @(posedge clock) begin
    toggle_q <= ~toggle_q;
    in_valid <= run;
    for (int k = 0; k < 4; k++) begin
      if (run) begin
        osc_phase[k] <= osc_phase[k] + 16'h1000;
      end
    end
  end
  // A stalling reader accepts on every second cycle only.
  assign dump_ready = !stall || toggle_q;
endmodule

// ===== verif/boxcar_averager_tb.sv
`timescale 1ns/1ps
bind boxcar_averager boxcar_asserts chk (.clock, .rst_n, .paddr, .psel, .penable, .pready,
  .pslverr, .in_valid, .period_out, .filt_valid, .dump_valid, .dump_word, .dump_ready);
module boxcar_averager_tb;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, in_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic signed [15:0] src_data [8];
  logic [15:0] osc_phase [4];
  boxcar_pkg::period_sum_t period_out;
  logic filt_valid, dump_valid, dump_ready, irq, run, stall, rerr;
  logic signed [47:0] filt_sum;
  boxcar_pkg::bin_word_t dump_word;
  int n_fail, check_count;
  boxcar_averager uut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .in_valid, .src_data, .osc_phase, .period_out, .filt_valid,
    .filt_sum, .dump_valid, .dump_word, .dump_ready, .irq);
  phase_source far_side (.clock, .run, .stall, .in_valid, .src_data, .osc_phase,
    .dump_ready);
  task complete_run();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check_val(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task timed_out();
    n_fail++;
    $display("FAIL %0t wait limit reached", $time);
    complete_run();
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    check_val(48'(rdata), 48'(exp));
    check_val(48'(rerr), 48'(err));
  endtask
  task wait_pulse(output int gap);
    gap = 0;
    do begin
      @(posedge clock);
      gap++;
    end while (period_out.valid !== 1'b1 && gap < 200);
    if (gap >= 200) timed_out();
  endtask
  task count_pulses(input int cycles, output int np, output int nf);
    np = 0;
    nf = 0;
    repeat (cycles) begin
      @(posedge clock);
      np += int'(period_out.valid === 1'b1);
      nf += int'(filt_valid === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task test_regs();
    rd_chk(boxcar_pkg::CTRL_OFS, 32'h0, 1'b0);
    rd_chk(boxcar_pkg::GATE_OFS, boxcar_pkg::GATE_RST, 1'b0);
    rd_chk(boxcar_pkg::AVG_OFS, 32'(boxcar_pkg::AVG_RST), 1'b0);
    rd_chk(boxcar_pkg::SHOT_LO_OFS, 32'h400, 1'b0);
    rd_chk(boxcar_pkg::STEP_OFS, boxcar_pkg::STEP_RST, 1'b0);
    apb(1'b1, 8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'h0, 1'b1);
    apb(1'b1, boxcar_pkg::ZOOM_OFS, 32'h0002_1234);
    rd_chk(boxcar_pkg::ZOOM_OFS, 32'h0002_1234, 1'b0);
    apb(1'b1, boxcar_pkg::CTRL_OFS, 32'h1 << boxcar_pkg::RANGE_RST_BIT);
    rd_chk(boxcar_pkg::ZOOM_OFS, 32'h0, 1'b0);
  endtask
  task test_period();
    int gap, np, nf;
    apb(1'b1, boxcar_pkg::GATE_OFS, 32'h8000_0000);
    apb(1'b1, boxcar_pkg::AVG_OFS, 32'h4);
    apb(1'b1, boxcar_pkg::CTRL_OFS, 32'h1);
    repeat (7) wait_pulse(gap);
    check_val(48'(gap), 48'h10);
    check_val(48'(period_out.sum), 48'h18);
    check_val(48'(filt_sum), 48'h60);
    rd_chk(boxcar_pkg::FILT_OFS, 32'h60, 1'b0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, boxcar_pkg::AVG_OFS, 32'd512 << i);
      count_pulses(64, np, nf);
      count_pulses(128, np, nf);
      check_val(48'(nf), 48'(8 >> i));
    end
    apb(1'b1, boxcar_pkg::CTRL_OFS, 32'h0);
    count_pulses(64, np, nf);
    count_pulses(64, np, nf);
    check_val(48'(np), 48'h0);
  endtask
  // Starts acquisition with the given control word and judges one full bin dump.
  task one_shot(input logic [31:0] ctrl, input logic [47:0] cnt, input logic [47:0] sum,
    input logic [15:0] top);
    logic [47:0] tot_sum, tot_cnt;
    logic [15:0] mx;
    int idx, n, bad;
    apb(1'b1, boxcar_pkg::CTRL_OFS, ctrl);
    tot_sum = '0;
    tot_cnt = '0;
    mx = '0;
    idx = 0;
    n = 0;
    bad = 0;
    while (idx < 1024 && n < 6000) begin
      @(posedge clock);
      n++;
      if (dump_valid === 1'b1 && dump_ready === 1'b1) begin
        bad += int'(dump_word.bin !== 10'(idx));
        tot_sum += 48'(dump_word.sum);
        tot_cnt += 48'(dump_word.cnt);
        if (dump_word.cnt > mx) mx = dump_word.cnt;
        idx++;
      end
    end
    if (idx < 1024) timed_out();
    check_val(48'(bad), 48'h0);
    check_val(tot_cnt, cnt);
    check_val(tot_sum, sum);
    check_val(48'(mx), 48'(top));
  endtask
  // Samples step an eighth of a period, so 16 ticks hit 8 bins twice each.
  task test_shots();
    apb(1'b1, boxcar_pkg::SHOT_LO_OFS, 32'h10);
    apb(1'b1, boxcar_pkg::SHOT_HI_OFS, 32'h0);
    apb(1'b1, boxcar_pkg::IRQ_MASK_OFS, 32'h0);
    for (int s = 0; s < 8; s++) begin
      stall <= s[0];
      one_shot((32'(s) << boxcar_pkg::PWA_SRC_LSB) | 32'h4, 48'h10, 48'(16 * (s + 3)),
        16'h2);
    end
    one_shot(32'h0007_0034, 48'h10, 48'h40, 16'h2);
    apb(1'b1, boxcar_pkg::HARM_OFS, 32'h2);
    one_shot(32'h4, 48'h10, 48'h30, 16'h4);
    apb(1'b1, boxcar_pkg::HARM_OFS, 32'h1);
    apb(1'b1, boxcar_pkg::ZOOM_OFS, 32'h0001_0000);
    one_shot(32'h4, 48'h8, 48'h18, 16'h2);
    one_shot(32'h2, 48'h8, 48'h18, 16'h2);
    one_shot(32'h2, 48'h8, 48'h18, 16'h2);
    apb(1'b1, boxcar_pkg::CTRL_OFS, 32'h0);
    repeat (200) @(posedge clock);
    check_val(48'(dump_valid), 48'h0);
    rd_chk(boxcar_pkg::STATE_OFS, 32'h2, 1'b0);
    check_val(48'(irq), 48'h0);
    apb(1'b0, boxcar_pkg::IRQ_STAT_OFS, 32'h0);
    check_val(48'(rdata[boxcar_pkg::EV_SHOT]), 48'h1);
    check_val(48'(rdata[boxcar_pkg::EV_UNEVEN]), 48'h1);
    apb(1'b1, boxcar_pkg::IRQ_MASK_OFS, 32'h1 << boxcar_pkg::EV_SHOT);
    repeat (2) @(posedge clock);
    check_val(48'(irq), 48'h1);
    apb(1'b1, boxcar_pkg::IRQ_STAT_OFS, 32'h1 << boxcar_pkg::EV_SHOT);
    repeat (2) @(posedge clock);
    check_val(48'(irq), 48'h0);
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    stall = 1'b0;
    n_fail = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clock);
    test_regs();
    test_period();
    test_shots();
    complete_run();
  end
endmodule
